// >>> verilog/spse_defines.svh
`ifndef SPSE_DEFINES_SVH
`define SPSE_DEFINES_SVH

// Register byte offsets
`define SPSE_ADDR_BUFFER 4'h0
`define SPSE_ADDR_CONTROL 4'h4
`define SPSE_ADDR_CONFIG 4'h8

// Control register fields
`define SPSE_CTL_MODE_HI 7
`define SPSE_CTL_MODE_LO 6
`define SPSE_CTL_MP 5
`define SPSE_CTL_REN 4
`define SPSE_CTL_TX9 3
`define SPSE_CTL_RX9 2
`define SPSE_CTL_TF 1
`define SPSE_CTL_RF 0
`define SPSE_CTL_RESET 8'h00

// Config register fields
`define SPSE_CFG_X6 0
`define SPSE_CFG_RATE_DOUBLE 1
`define SPSE_CFG_T2_SEL 2

// Machine cycle positions, index = (state - 1) * 2 + phase - 1
`define SPSE_POS_S1P1 4'h0
`define SPSE_POS_S3P1 4'h4
`define SPSE_POS_S5P2 4'h9
`define SPSE_POS_S6P1 4'hA
`define SPSE_POS_S6P2 4'hB
`define SPSE_POS_LAST 4'hB
`define SPSE_POS_LAST_X6 3'h5

// Shift register patterns
`define SPSE_RX0_LOAD 8'hFE
`define SPSE_RXA_LOAD 9'h1FF
`define SPSE_TX_MARK 8'h01

// Divide-by-16 counter sample points
`define SPSE_C16_S7 4'h7
`define SPSE_C16_S8 4'h8
`define SPSE_C16_S9 4'h9
`define SPSE_C16_TOP 4'hF

// Mode 2 prescale to the 16x rate, value minus one
`define SPSE_PRE12_SLOW 2'h3
`define SPSE_PRE12_FAST 2'h1
`define SPSE_PRE6_SLOW 2'h1
`define SPSE_PRE6_FAST 2'h0

`endif

// >>> verilog/spse_pkg.sv
package spse_pkg;

   typedef enum logic [1:0] {
      SPSE_MODE_SHIFT = 2'b00,
      SPSE_MODE_ASYNC8 = 2'b01,
      SPSE_MODE_FIXED9 = 2'b10,
      SPSE_MODE_VAR9 = 2'b11
   } spse_mode_t;

   typedef struct packed {
      logic [3:0] pos;
      logic [1:0] pre;
      logic thalf;
      logic [3:0] c16;
      logic [7:0] ctrl;
      logic [7:0] serial_buffer_rx;
      logic x6;
      logic rate_double;
      logic t2_sel;
      logic tx_pend;
      logic tx_arm;
      logic send;
      logic data_on;
      logic stop_in;
      logic tx_last;
      logic [8:0] tsr;
      logic rx_arm;
      logic rx_load;
      logic rx_act;
      logic rx_first;
      logic rx_last;
      logic [8:0] rsr;
      logic [1:0] vote;
      logic rx_prev;
      logic [1:0] rx_sync;
      logic pin0_out;
      logic pin0_oe;
      logic pin1_out;
      logic ack;
      logic wreq;
      logic [31:0] rdata;
   } spse_state_t;

endpackage : spse_pkg

// >>> verilog/spse_top.sv
// Notes on behaviour
// [RULE1] Shift mode: data both ways on pin 0, clock on pin 1, 8 bits LSB first
// [RULE2] Shift mode bit rate is oscillator/12, or oscillator/6 in 6-clock mode
// [RULE3] Shift mode buffer write loads marker one; send rises one machine cycle later
// [RULE4] Shift clock low in states 3-5, high 6,1,2; shift right at S6P2
// [RULE5] Zeros fill; marker beside MSB gives last shift, send off, flag at S1P1
// [RULE6] Shift receive starts on enable and clear flag; load 11111110, then active
// [RULE7] Receive clock toggles S3P1, S6P1; shift left at S6P2 with S5P2 sample
// [RULE8] Zero at left end: last shift, load buffer, active off, flag set S1P1
// [RULE9] 8-bit frame: start zero, 8 data LSB first, stop one into ninth flag
// [RULE10] 8-bit mode rate follows the selected timer 1 or timer 2 overflow
// [RULE11] Async buffer write only posts request; start follows next counter rollover
// [RULE12] Start bit first, data output one bit later, first shift one after that
// [RULE13] 8-bit transmit ends at tenth rollover: last shift, send off, flag set
// [RULE14] 9-bit: ninth bit loaded, first shift inserts one, ends eleventh rollover
// [RULE15] Async receive starts on falling edge at 16x; counter reset, load 1FF
// [RULE16] Each bit sampled at counter states 7, 8, 9; majority taken
// [RULE17] Start bit not zero: receiver resets and searches again
// [RULE18] 8-bit end: store only if flag clear and multiprocessor off or stop one
// [RULE19] After every async frame the receiver searches for a falling edge again
// [RULE20] 9-bit frame: start, 8 data LSB first, ninth bit, stop; ninth stored
// [RULE21] Mode 2 rate oscillator/64 or /32, or /32 or /16 in 6-clock mode
// [RULE22] Modes 2 and 3 receive exactly as 8-bit mode with 9-bit register
// [RULE23] 9-bit store only if flag clear and multiprocessor off or ninth bit one
// [RULE24] Software clears both flags; hardware only sets them
// [RULE25] Mode field 00 shift, 01 8-bit, 10 9-bit fixed, 11 9-bit variable
// [RULE26] Machine cycle is six states of two phases from the oscillator
`include "spse_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module spse_top (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Serial pins
   input wire logic port3_bit0_pin_in,
   output logic port3_bit0_pin_out,
   output logic port3_bit0_pin_oe,
   output logic port3_bit1_pin,
   // Timer overflow pulses
   input wire logic timer1_overflow,
   input wire logic timer2_overflow
);
   import spse_pkg::*;

   function automatic logic at_pos(input logic [3:0] p, input logic [3:0] k, input logic x6);
      at_pos = x6 ? (p[3:1] == k[3:1]) : (p == k);
   endfunction : at_pos

   function automatic logic maj3(input logic [2:0] v);
      maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction : maj3

   function automatic logic [7:0] rev8(input logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         rev8[i] = v[7 - i];
      end
   endfunction : rev8

   spse_state_t s;
   spse_state_t next_s;

   spse_mode_t mode;
   logic req;
   logic bus_wr;
   logic buf_wr;
   logic ctl_wr;
   logic cfg_wr;
   logic ev_s1p1;
   logic ev_s5p2;
   logic ev_s6p2;
   logic ovf;
   logic [1:0] pre_top;
   logic tick16;
   logic roll;
   logic rx_pin;
   logic rx_edge;
   logic rx_bit;
   logic rx_sample;
   logic tx_final;
   logic rx_final;

   assign mode = spse_mode_t'(s.ctrl[`SPSE_CTL_MODE_HI:`SPSE_CTL_MODE_LO]); // [RULE25]
   assign req = avs_read | avs_write;
   assign bus_wr = avs_write & s.ack;
   assign buf_wr = bus_wr & (avs_address == `SPSE_ADDR_BUFFER);
   assign ctl_wr = bus_wr & (avs_address == `SPSE_ADDR_CONTROL);
   assign cfg_wr = bus_wr & (avs_address == `SPSE_ADDR_CONFIG);
   // State and phase events
   assign ev_s1p1 = at_pos(s.pos, `SPSE_POS_S1P1, s.x6); // [RULE26]
   assign ev_s5p2 = at_pos(s.pos, `SPSE_POS_S5P2, s.x6);
   assign ev_s6p2 = at_pos(s.pos, `SPSE_POS_S6P2, s.x6);
   // 16x rate
   assign ovf = s.t2_sel ? timer2_overflow : timer1_overflow; // [RULE10]
   assign pre_top = s.x6 ? (s.rate_double ? `SPSE_PRE6_FAST : `SPSE_PRE6_SLOW)
                         : (s.rate_double ? `SPSE_PRE12_FAST : `SPSE_PRE12_SLOW); // [RULE21]
   always_comb begin
      unique case (mode)
         SPSE_MODE_SHIFT: tick16 = 1'b0;
         SPSE_MODE_FIXED9: tick16 = (s.pre == pre_top);
         SPSE_MODE_ASYNC8, SPSE_MODE_VAR9: tick16 = ovf & (s.rate_double | s.thalf);
      endcase
   end
   assign roll = tick16 & (s.c16 == `SPSE_C16_TOP);
   assign rx_pin = s.rx_sync[1];
   assign rx_edge = tick16 & s.ctrl[`SPSE_CTL_REN] & ~s.rx_act & s.rx_prev & ~rx_pin;
   assign rx_sample = tick16 & s.rx_act & (s.c16 == `SPSE_C16_S9);
   assign rx_bit = maj3({s.vote, rx_pin});
   assign tx_final = roll & s.send & s.data_on & (s.tsr[8:1] == 8'(`SPSE_TX_MARK))
                     & ((mode == SPSE_MODE_ASYNC8) | s.stop_in);
   assign rx_final = rx_sample & ~s.rx_first & ~s.rsr[8];

   always_comb begin
      next_s = s;
      next_s.rx_sync = {s.rx_sync[0], port3_bit0_pin_in};
      // Machine cycle position
      if (s.x6) begin
         next_s.pos = (s.pos[3:1] == `SPSE_POS_LAST_X6) ? 4'h0 : {3'(s.pos[3:1] + 3'h1), 1'b0}; // [RULE2]
      end else begin
         next_s.pos = (s.pos == `SPSE_POS_LAST) ? 4'h0 : 4'(s.pos + 4'h1); // [RULE2]
      end
      next_s.pre = (mode != SPSE_MODE_FIXED9 || s.pre == pre_top) ? 2'h0 : 2'(s.pre + 2'h1);
      if (ovf) begin
         next_s.thalf = ~s.thalf;
      end
      if (tick16) begin
         next_s.c16 = 4'(s.c16 + 4'h1);
         next_s.rx_prev = rx_pin;
      end
      // Bus slave, one wait cycle
      next_s.ack = req & ~s.ack;
      next_s.wreq = ~(req & ~s.ack);
      if (req && !s.ack) begin
         unique case (avs_address)
            `SPSE_ADDR_BUFFER: next_s.rdata = {24'h000000, s.serial_buffer_rx};
            `SPSE_ADDR_CONTROL: next_s.rdata = {24'h000000, s.ctrl};
            `SPSE_ADDR_CONFIG: next_s.rdata = {29'h00000000, s.t2_sel, s.rate_double, s.x6};
            default: next_s.rdata = 32'h00000000;
         endcase
      end
      if (ctl_wr) begin
         next_s.ctrl = avs_writedata[7:0]; // [RULE24]
      end
      if (cfg_wr) begin
         next_s.x6 = avs_writedata[`SPSE_CFG_X6];
         next_s.rate_double = avs_writedata[`SPSE_CFG_RATE_DOUBLE];
         next_s.t2_sel = avs_writedata[`SPSE_CFG_T2_SEL];
      end
      if (buf_wr) begin
         next_s.tx_pend = 1'b1; // [RULE11]
         if (mode == SPSE_MODE_SHIFT || mode == SPSE_MODE_ASYNC8) begin
            next_s.tsr = {1'b1, avs_writedata[7:0]}; // [RULE3]
         end else begin
            next_s.tsr = {s.ctrl[`SPSE_CTL_TX9], avs_writedata[7:0]}; // [RULE14]
         end
      end
      if (mode == SPSE_MODE_SHIFT) begin
         // Shift register transmit
         if (ev_s6p2) begin
            if (s.tx_pend && !s.tx_arm && !s.send) begin
               next_s.tx_arm = 1'b1; // [RULE3]
               next_s.tx_pend = buf_wr;
            end else if (s.tx_arm) begin
               next_s.tx_arm = 1'b0;
               next_s.send = 1'b1; // [RULE3]
            end else if (s.send && !s.tx_last) begin
               next_s.tsr = {1'b0, s.tsr[8:1]}; // [RULE4] [RULE5]
               next_s.tx_last = (s.tsr[8:1] == 8'(`SPSE_TX_MARK)); // [RULE5]
            end
         end
         if (ev_s1p1 && s.tx_last) begin
            next_s.tx_last = 1'b0;
            next_s.send = 1'b0; // [RULE5]
            next_s.ctrl[`SPSE_CTL_TF] = 1'b1; // [RULE5]
         end
         // Shift register receive
         if (ev_s5p2) begin
            next_s.vote[0] = rx_pin; // [RULE7]
         end
         if (ev_s6p2) begin
            if (s.ctrl[`SPSE_CTL_REN] && !s.ctrl[`SPSE_CTL_RF] && !s.rx_arm && !s.rx_act && !s.rx_load) begin
               next_s.rx_arm = 1'b1; // [RULE6]
            end else if (s.rx_arm) begin
               next_s.rx_arm = 1'b0;
               next_s.rsr = {1'b1, `SPSE_RX0_LOAD}; // [RULE6]
               next_s.rx_load = 1'b1;
            end else if (s.rx_act && !s.rx_last) begin
               next_s.rsr[7:0] = {s.rsr[6:0], s.vote[0]}; // [RULE7]
               if (!s.rsr[7]) begin
                  next_s.serial_buffer_rx = rev8({s.rsr[6:0], s.vote[0]}); // [RULE8] [RULE1]
                  next_s.rx_last = 1'b1;
               end
            end
         end
         if (s.rx_load) begin
            next_s.rx_load = 1'b0;
            next_s.rx_act = 1'b1; // [RULE6]
         end
         if (ev_s1p1 && s.rx_last) begin
            next_s.rx_last = 1'b0;
            next_s.rx_act = 1'b0; // [RULE8]
            next_s.ctrl[`SPSE_CTL_RF] = 1'b1; // [RULE8]
         end
      end else begin
         // Asynchronous transmit
         if (roll) begin
            if (s.tx_pend && !s.send) begin
               next_s.tx_pend = buf_wr;
               next_s.send = 1'b1; // [RULE11] [RULE12]
               next_s.data_on = 1'b0;
               next_s.stop_in = 1'b0;
            end else if (s.send && !s.data_on) begin
               next_s.data_on = 1'b1; // [RULE12]
            end else if (s.send) begin
               next_s.tsr = {(mode != SPSE_MODE_ASYNC8) & ~s.stop_in, s.tsr[8:1]}; // [RULE14]
               next_s.stop_in = 1'b1;
               if (tx_final) begin
                  next_s.send = 1'b0; // [RULE13] [RULE14]
                  next_s.ctrl[`SPSE_CTL_TF] = 1'b1; // [RULE13] [RULE14]
               end
            end
         end
         // Asynchronous receive, identical for modes 1 to 3
         if (rx_edge) begin
            next_s.c16 = 4'h0; // [RULE15]
            next_s.rsr = `SPSE_RXA_LOAD; // [RULE15]
            next_s.rx_act = 1'b1;
            next_s.rx_first = 1'b1;
         end
         if (tick16 && s.rx_act && (s.c16 == `SPSE_C16_S7 || s.c16 == `SPSE_C16_S8)) begin
            next_s.vote = {s.vote[0], rx_pin}; // [RULE16]
         end
         if (rx_sample) begin
            if (s.rx_first && rx_bit) begin
               next_s.rx_act = 1'b0; // [RULE17]
            end else if (rx_final) begin
               next_s.rx_act = 1'b0; // [RULE19]
               if (!s.ctrl[`SPSE_CTL_RF] && (!s.ctrl[`SPSE_CTL_MP] || rx_bit)) begin
                  next_s.serial_buffer_rx = rev8(s.rsr[7:0]); // [RULE18] [RULE23] [RULE9] [RULE20]
                  next_s.ctrl[`SPSE_CTL_RX9] = rx_bit; // [RULE9] [RULE20]
                  next_s.ctrl[`SPSE_CTL_RF] = 1'b1; // [RULE18] [RULE23]
               end
            end else begin
               next_s.rsr = {s.rsr[7:0], rx_bit}; // [RULE16] [RULE22]
               next_s.rx_first = 1'b0;
            end
         end
      end
      // Pin drive
      if (mode == SPSE_MODE_SHIFT) begin
         next_s.pin0_oe = s.send; // [RULE1]
         next_s.pin0_out = s.send ? s.tsr[0] : 1'b1; // [RULE1]
         next_s.pin1_out = ~((s.send | s.rx_act) && s.pos >= `SPSE_POS_S3P1 && s.pos < `SPSE_POS_S6P1); // [RULE4] [RULE7]
      end else begin
         next_s.pin0_oe = 1'b0;
         next_s.pin0_out = 1'b1;
         next_s.pin1_out = s.send ? (s.data_on & s.tsr[0]) : 1'b1; // [RULE12]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         s <= '0;
         s.ctrl <= `SPSE_CTL_RESET;
         s.pin0_out <= 1'b1;
         s.pin1_out <= 1'b1;
         s.rx_prev <= 1'b1;
         s.rx_sync <= 2'b11;
         s.wreq <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign avs_readdata = s.rdata;
   assign avs_waitrequest = s.wreq;
   assign port3_bit0_pin_out = s.pin0_out;
   assign port3_bit0_pin_oe = s.pin0_oe;
   assign port3_bit1_pin = s.pin1_out;

   // Checks
   bus_wait_one_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (req && s.wreq) |=> !avs_waitrequest)
      else $error("waitrequest not released after one cycle");

   shift_clock_low_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE4]
      (mode == SPSE_MODE_SHIFT && s.send && $past(s.send) && $past(mode) == SPSE_MODE_SHIFT
       && $past(s.pos) >= 4'h4 && $past(s.pos) <= 4'h9) |-> !port3_bit1_pin)
      else $error("shift clock high during states 3 to 5");

   shift_zero_fill_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE5]
      (mode == SPSE_MODE_SHIFT && s.send && ev_s6p2 && !s.tx_last && !s.tx_arm && !buf_wr) |=> !s.tsr[8])
      else $error("no zero filled from the left");

   rx0_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE6]
      (mode == SPSE_MODE_SHIFT && ev_s6p2 && s.rx_arm) |=> (s.rsr[7:0] == 8'hFE) ##1 s.rx_act)
      else $error("receive register not loaded before receive active");

   async_start_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE15]
      (mode != SPSE_MODE_SHIFT && rx_edge) |=> (s.c16 == 4'h0 && s.rsr == 9'h1FF && s.rx_act))
      else $error("falling edge did not restart counter and register");

   false_start_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE17]
      (mode != SPSE_MODE_SHIFT && rx_sample && s.rx_first && rx_bit) |=> !s.rx_act)
      else $error("false start not rejected");

   drop_frame_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE18]
      (mode != SPSE_MODE_SHIFT && rx_final && s.ctrl[0]) |=> $stable(s.serial_buffer_rx))
      else $error("frame stored while receive flag set");

   tx_end_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE13]
      (mode != SPSE_MODE_SHIFT && tx_final) |=> (!s.send && s.ctrl[1]) ##1 port3_bit1_pin)
      else $error("transmit end not flagged");

   start_bit_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE12]
      (mode != SPSE_MODE_SHIFT && s.send && !s.data_on) ##1 (s.send && !s.data_on) |-> !port3_bit1_pin)
      else $error("start bit not driven low");

   set_wins_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE24]
      (ctl_wr && !avs_writedata[0] && rx_final && !s.ctrl[0] && !s.ctrl[5]) |=> s.ctrl[0])
      else $error("receive flag lost to software clear");

   send_after_arm_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE3]
      (mode == SPSE_MODE_SHIFT && ev_s6p2 && s.tx_arm) |=> s.send)
      else $error("send not raised one machine cycle after write");

   shift_right_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE4]
      (mode == SPSE_MODE_SHIFT && s.send && ev_s6p2 && !s.tx_last && !s.tx_arm && !buf_wr)
      |=> (s.tsr[7:0] == $past(s.tsr[8:1])))
      else $error("transmit register not shifted right");

   rx0_end_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE8]
      (mode == SPSE_MODE_SHIFT && ev_s1p1 && s.rx_last) |=> (s.ctrl[0] && !s.rx_act))
      else $error("shift receive end not flagged");

   post_only_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE11]
      (mode != SPSE_MODE_SHIFT && !roll && !ctl_wr) |=> $stable(s.send))
      else $error("transmit started off a counter rollover");

   stop_insert_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE14]
      ((mode == SPSE_MODE_FIXED9 || mode == SPSE_MODE_VAR9) && roll && s.send && s.data_on && !s.stop_in)
      |=> s.tsr[8])
      else $error("first shift did not insert a one");

   vote_shift_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE16]
      (mode != SPSE_MODE_SHIFT && rx_sample && !(s.rx_first && rx_bit) && !rx_final)
      |=> (s.rsr[0] == $past(rx_bit)))
      else $error("majority value not shifted in");

   resume_search_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE19]
      (mode != SPSE_MODE_SHIFT && rx_final) |=> !s.rx_act)
      else $error("receiver did not resume edge search");

   ninth_store_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE23]
      ((mode == SPSE_MODE_FIXED9 || mode == SPSE_MODE_VAR9) && rx_final && !s.ctrl[0]
       && (!s.ctrl[5] || rx_bit)) |=> (s.ctrl[0] && s.ctrl[2] == $past(rx_bit)))
      else $error("ninth bit not stored");

   tx0_done_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
      mode == SPSE_MODE_SHIFT && ev_s1p1 && s.tx_last);
   rx0_done_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
      mode == SPSE_MODE_SHIFT && ev_s1p1 && s.rx_last);
   rx_accept_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
      rx_final && !s.ctrl[0]);
   rx_false_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
      rx_sample && s.rx_first && rx_bit);

endmodule : spse_top

`default_nettype wire

// >>> testbench/spse_far_end.sv
`timescale 1ns/1ps
`default_nettype none

module spse_far_end (
   // Clock for bit timing
   input wire logic clk_sys,
   // Pins seen from the far side
   input wire logic line_out,
   input wire logic data_pin,
   output logic drive
);
   // Line idles high, driven high from the far end
   initial drive = 1'b1;

   // Async frame out, first bit first, then released high
   task automatic uart_send(input logic [10:0] f, input int n, input int bc);
      for (int i = 0; i < n; i++) begin
         drive <= f[i];
         repeat (bc) @(posedge clk_sys);
      end
      drive <= 1'b1;
      repeat (2 * bc) @(posedge clk_sys);
   endtask : uart_send

   // Async frame in, start width in clocks, bits at mid-bit
   task automatic uart_recv(input int bc, output logic [10:0] f, output int sw);
      sw = 0;
      f = 11'h000;
      @(negedge line_out);
      @(negedge clk_sys);
      while (line_out === 1'b0) begin
         sw++;
         @(negedge clk_sys);
      end
      repeat (bc / 2) @(negedge clk_sys);
      for (int i = 1; i < 11; i++) begin
         f[i] = line_out;
         repeat (bc) @(negedge clk_sys);
      end
   endtask : uart_recv

   // Shift mode capture on falling shift clock, mid data bit
   task automatic shift_capture(output logic [7:0] d, output int per, output int low);
      time tf;
      tf = 0;
      for (int i = 0; i < 8; i++) begin
         @(negedge line_out);
         if (i == 1) per = int'(($time - tf) / 50);
         tf = $time;
         d[i] = data_pin;
         if (i == 0) begin
            @(posedge line_out);
            low = int'(($time - tf) / 50);
         end
      end
   endtask : shift_capture

   // Shift mode source, next bit after each rising shift clock
   task automatic shift_feed(input logic [7:0] d);
      drive <= d[0];
      for (int i = 1; i < 8; i++) begin
         @(posedge line_out);
         drive <= d[i];
      end
      @(posedge line_out);
      drive <= 1'b1;
   endtask : shift_feed
endmodule : spse_far_end

`default_nettype wire

// >>> testbench/tb_serial_port_shift_engine.sv
`timescale 1ns/1ps
`default_nettype none

module tb_serial_port_shift_engine;
   import spse_pkg::*;
   logic clk_sys, reset_n, avs_read, avs_write, avs_waitrequest, wait_s;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rdat_s, q;
   logic pin0_out, pin0_oe, pin1, far_drive, pin0_level, timer1_overflow, timer2_overflow;
   logic [10:0] fr;
   logic [7:0] d8;
   int miscompares, checks, tcnt, sw, per, low;
   logic [7:0] tx_ctl [7] = '{8'h88, 8'h88, 8'h88, 8'h88, 8'h40, 8'h40, 8'hC0};
   logic [2:0] tx_cfg [7] = '{3'h0, 3'h2, 3'h1, 3'h3, 3'h2, 3'h0, 3'h6};
   int tx_bit [7] = '{64, 32, 32, 16, 32, 64, 48};

   assign pin0_level = pin0_oe ? pin0_out : far_drive;

   spse_top uut (
      .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .port3_bit0_pin_in(pin0_level), .port3_bit0_pin_out(pin0_out),
      .port3_bit0_pin_oe(pin0_oe), .port3_bit1_pin(pin1), .timer1_overflow(timer1_overflow),
      .timer2_overflow(timer2_overflow)
   );

   spse_far_end far (.clk_sys(clk_sys), .line_out(pin1), .data_pin(pin0_level), .drive(far_drive));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // Bus answer as it stood just before each rising edge
   always @(negedge clk_sys) begin
      wait_s = avs_waitrequest;
      rdat_s = avs_readdata;
   end

   // Timer overflow pulses, every 2 and every 3 clocks
   always @(posedge clk_sys) begin
      tcnt <= tcnt + 1;
      timer1_overflow <= (tcnt % 2 == 0);
      timer2_overflow <= (tcnt % 3 == 0);
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wait_s !== 1'b0 && n < 40);
      q = rdat_s;
      if (n >= 40) miscompares++;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask : bus

   task automatic rdc(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rdc

   task automatic poll(input logic [7:0] m);
      int n;
      n = 0;
      do begin
         bus(1'b0, 4'h4, 32'h0);
         n++;
      end while ((q[7:0] & m) == 8'h00 && n < 400);
   endtask : poll

   task automatic rx_case(input logic [10:0] f, input int n, input logic [7:0] ectl, input logic [7:0] ebuf);
      far.uart_send(f, n, 32);
      rdc(4'h4, {24'h0, ectl});
      rdc(4'h0, {24'h0, ebuf});
      $display("test receive frame %h done", f);
   endtask : rx_case

   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (40000) @(posedge clk_sys);
      miscompares++;
      tally_and_finish();
   end

   initial begin
      reset_n = 1'b0;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      timer1_overflow = 1'b0;
      timer2_overflow = 1'b0;
      tcnt = 0;
      miscompares = 0;
      checks = 0;
      repeat (5) @(posedge clk_sys);
      chk({29'h0, avs_waitrequest, pin1, pin0_oe}, 32'h6);
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      rdc(4'h4, 32'h0);
      rdc(4'h0, 32'h0);
      bus(1'b1, 4'hC, 32'hFF);
      rdc(4'hC, 32'h0);
      rdc(4'h4, 32'h0);
      $display("test reset and unmapped done");
      // Shift mode transmit in 12-clock and 6-clock mode
      for (int x = 0; x < 2; x++) begin
         bus(1'b1, 4'h8, 32'(x));
         bus(1'b1, 4'h4, 32'h00);
         fork
            far.shift_capture(d8, per, low);
            bus(1'b1, 4'h0, 32'hA5);
         join
         chk(d8, 8'hA5);
         chk(per, 32'(12 >> x));
         chk(low, 32'(6 >> x));
         poll(8'h02);
         chk(q, 32'h02);
         $display("test shift transmit %0d done", x);
      end
      // Shift mode receive
      bus(1'b1, 4'h8, 32'h0);
      fork
         far.shift_feed(8'h3C);
         bus(1'b1, 4'h4, 32'h10);
      join
      poll(8'h01);
      chk(q[1:0], 2'b01);
      rdc(4'h0, 32'h3C);
      bus(1'b1, 4'h4, 32'h00);
      $display("test shift receive done");
      // Async transmit over every async mode, all four mode 2 rates
      for (int k = 0; k < 7; k++) begin
         bus(1'b1, 4'h8, {29'h0, tx_cfg[k]});
         bus(1'b1, 4'h4, {24'h0, tx_ctl[k]});
         fork
            far.uart_recv(tx_bit[k], fr, sw);
            bus(1'b1, 4'h0, 32'hA5);
         join
         chk(sw, tx_bit[k]);
         chk(fr, {1'b1, tx_ctl[k][7] ? tx_ctl[k][3] : 1'b1, 8'hA5, 1'b0});
         poll(8'h02);
         chk(q, {24'h0, tx_ctl[k] | 8'h02});
         $display("test async transmit %0d done", k);
      end
      // Async receive, 9-bit fixed rate then 8-bit timer rate
      bus(1'b1, 4'h8, 32'h2);
      bus(1'b1, 4'h4, 32'h90);
      rx_case({2'b10, 8'h3C, 1'b0}, 11, 8'h91, 8'h3C);
      rx_case({2'b11, 8'h55, 1'b0}, 11, 8'h91, 8'h3C);
      bus(1'b1, 4'h4, 32'hB0);
      rx_case({2'b10, 8'h66, 1'b0}, 11, 8'hB0, 8'h3C);
      rx_case({2'b11, 8'h99, 1'b0}, 11, 8'hB5, 8'h99);
      bus(1'b1, 4'h4, 32'h90);
      far.uart_send(11'h000, 1, 4);
      repeat (40) @(posedge clk_sys);
      rx_case({2'b11, 8'h5A, 1'b0}, 11, 8'h95, 8'h5A);
      bus(1'b1, 4'h4, 32'h50);
      rx_case({1'b1, 8'hC3, 1'b0}, 10, 8'h55, 8'hC3);
      bus(1'b1, 4'h4, 32'h70);
      rx_case({1'b0, 8'h11, 1'b0}, 10, 8'h70, 8'hC3);
      tally_and_finish();
   end
endmodule : tb_serial_port_shift_engine

`default_nettype wire
